// ==== core/ac_link_pkg.sv ====
// shared constants and carriers for the ac-link slot formatter
package ac_link_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_CMD_WRITE  = 5'h00;
  localparam logic [4:0] OFS_CMD_READ   = 5'h04;
  localparam logic [4:0] OFS_CODEC_REQ  = 5'h08;
  localparam logic [4:0] OFS_GPIO_WRITE = 5'h0c;
  localparam logic [4:0] OFS_GPIO_READ  = 5'h10;
  localparam logic [4:0] OFS_PLAY_CTRL  = 5'h14;

  // register field positions
  localparam int CMD_DATA_LSB   = 0;
  localparam int CMD_INDEX_LSB  = 16;
  localparam int CMD_RW_BIT     = 23;
  localparam int BUSY_BIT       = 31;
  localparam int IDX_VALID_BIT  = 24;
  localparam int DATA_VALID_BIT = 25;
  localparam int GPIO_VALID_BIT = 31;
  localparam int PLAY_LEFT_BIT  = 0;
  localparam int PLAY_RIGHT_BIT = 1;
  localparam int PLAY_MODEM_BIT = 2;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_TAG  = 16'h0000;

  // tag bit positions
  localparam int TAG_FRAME = 15;
  localparam int TAG_S1    = 14;
  localparam int TAG_S2    = 13;
  localparam int TAG_S3    = 12;
  localparam int TAG_S4    = 11;
  localparam int TAG_S5    = 10;
  localparam int TAG_S6    = 9;
  localparam int TAG_S12   = 3;

  // frame geometry
  localparam logic [4:0] TAG_LAST_POS  = 5'h0f;
  localparam logic [4:0] SLOT_LAST_POS = 5'h13;
  localparam logic [4:0] RX_IDLE_POS   = 5'h1f;
  localparam logic [3:0] SLOT_TAG      = 4'h0;
  localparam logic [3:0] SLOT_CMD_IDX  = 4'h1;
  localparam logic [3:0] SLOT_CMD_DAT  = 4'h2;
  localparam logic [3:0] SLOT_LEFT     = 4'h3;
  localparam logic [3:0] SLOT_RIGHT    = 4'h4;
  localparam logic [3:0] SLOT_MODEM    = 4'h5;
  localparam logic [3:0] SLOT_MIC      = 4'h6;
  localparam logic [3:0] SLOT_GPIO     = 4'hc;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
    logic [15:0] modem;
  } play_s;

  typedef struct packed {
    logic        left_valid;
    logic        right_valid;
    logic        modem_valid;
    logic [15:0] left;
    logic [15:0] right;
    logic [15:0] modem;
  } rec_s;

  typedef struct packed {
    logic status_index;
    logic status_data;
    logic gpio_status;
    logic gpio_int;
  } event_s;

endpackage

// ==== core/sync2.sv ====
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== core/sticky_flag.sv ====
// bank of flags, set wins over clear
`timescale 1ns/100ps
module sticky_flag #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flag_q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr) | set;
    end
  end
endmodule

// ==== core/ac_link_slot_formatter.sv ====
// ac-link frame builder and splitter with avalon-mm registers
// What this block does
// - outgoing frame-valid tag bit is high when slot 1-5 or 12 is valid.
// - a command register write marks slots 1 and 2 valid.
// - playback enables mark slots 3, 4 and 5 valid.
// - tag bits for slots 6-11 and the three lowest bits stay zero.
// - a gpio slot register write marks slot 12 valid.
// - slot 1 top bit carries the read/write command flag, one means read.
// - slot 1 carries the seven-bit register index, low twelve bits zero.
// - slot 2 carries sixteen write data bits, low four bits zero.
// - slots 3 and 4 carry left and right playback samples, low bits zero.
// - slot 5 carries modem line data unchanged, low bits zero.
// - slot 12 carries all twenty gpio slot write bits.
// - incoming slot 1, 2 or 12 valid raises a status event.
// - incoming slots 3, 4, 5, 6 feed left, right, modem, left record.
// - incoming slot 1 index bits land in the returned index field.
// - incoming slot 1 bits 11 to 2 land in the request register.
// - incoming slot 2 data bits land in the returned data field.
// - incoming slot 12 is captured whole; bit 0 set raises an event.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module ac_link_slot_formatter (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               ac_bit_clk,
  input  wire logic               ac_sdata_in,
  output logic                    ac_sync,
  output logic                    ac_sdata_out,
  input  wire ac_link_pkg::play_s play_sample,
  output logic      [2:0]         play_take,
  output ac_link_pkg::rec_s       rec_out,
  output ac_link_pkg::event_s     status_event
);

  // bus handshake: one wait cycle, then the answer
  logic        ack_q;
  logic [31:0] cmd_word_q;
  logic [19:0] gpio_wr_q;
  logic [2:0]  play_en_q;
  logic [6:0]  ret_idx_q;
  logic [15:0] ret_data_q;
  logic [9:0]  req_q;
  logic [19:0] gpio_rd_q;

  wire req_any   = avs_read | avs_write;
  wire bus_done  = req_any & ack_q;
  wire wr_done   = avs_write & bus_done;
  wire rd_done   = avs_read & bus_done;
  assign avs_waitrequest = req_any & ~ack_q;

  wire hit_cmd_wr  = (avs_address == ac_link_pkg::OFS_CMD_WRITE);
  wire hit_cmd_rd  = (avs_address == ac_link_pkg::OFS_CMD_READ);
  wire hit_req     = (avs_address == ac_link_pkg::OFS_CODEC_REQ);
  wire hit_gpio_wr = (avs_address == ac_link_pkg::OFS_GPIO_WRITE);
  wire hit_gpio_rd = (avs_address == ac_link_pkg::OFS_GPIO_READ);
  wire hit_play    = (avs_address == ac_link_pkg::OFS_PLAY_CTRL);

  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] gpio_wr_word = {12'h000, gpio_wr_q};
  wire [31:0] play_word    = {29'h0000_0000, play_en_q};
  wire [31:0] cmd_merge    = (cmd_word_q & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] gpio_merge   = (gpio_wr_word & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] play_merge   = (play_word & ~be_mask) | (avs_writedata & be_mask);

  wire wr_cmd  = wr_done & hit_cmd_wr;
  wire wr_gpio = wr_done & hit_gpio_wr;
  wire wr_play = wr_done & hit_play;
  wire rd_cmd  = rd_done & hit_cmd_rd;
  wire rd_gpio = rd_done & hit_gpio_rd;

  // flags: cmd pending, gpio pending, index valid, data valid, gpio valid
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [4:0] flag_q;
  wire cmd_pend  = flag_q[0];
  wire gpio_pend = flag_q[1];
  wire idx_valid = flag_q[2];
  wire dat_valid = flag_q[3];
  wire gpr_valid = flag_q[4];

  sticky_flag #(.W(5)) u_flags (
    .clk    (ref_clk),
    .rst_n  (rst_n),
    .set    (flag_set),
    .clr    (flag_clr),
    .flag_q (flag_q)
  );

  wire [31:0] cmd_rd_word = {6'h00, dat_valid, idx_valid, 1'b0, ret_idx_q, ret_data_q};
  wire [31:0] cmd_status  = {cmd_pend, 7'h00, cmd_word_q[23:0]};
  wire [31:0] gpio_status = {gpio_pend, 11'h000, gpio_wr_q};
  wire [31:0] gpio_rd_wrd = {gpr_valid, 11'h000, gpio_rd_q};
  wire [31:0] rd_mux = hit_cmd_wr  ? cmd_status :
                       hit_cmd_rd  ? cmd_rd_word :
                       hit_req     ? {22'h00_0000, req_q} :
                       hit_gpio_wr ? gpio_status :
                       hit_gpio_rd ? gpio_rd_wrd :
                       hit_play    ? play_word : ac_link_pkg::RST_WORD;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q        <= 1'b0;
      avs_readdata <= ac_link_pkg::RST_WORD;
    end else begin
      ack_q <= req_any & ~ack_q;
      if (avs_read & ~ack_q) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word_q <= ac_link_pkg::RST_WORD;
      gpio_wr_q  <= 20'h0_0000;
      play_en_q  <= 3'h0;
    end else begin
      if (wr_cmd) begin
        cmd_word_q <= {8'h00, cmd_merge[23:0]};
      end
      if (wr_gpio) begin
        gpio_wr_q <= gpio_merge[19:0];
      end
      if (wr_play) begin
        play_en_q <= play_merge[2:0];
      end
    end
  end

  // link side: sample bit clock and serial input
  logic [1:0] link_s;
  logic       bclk_d_q;
  wire        bclk_s = link_s[0];
  wire        sdin_s = link_s[1];
  wire        rise   = bclk_s & ~bclk_d_q;
  wire        fall   = ~bclk_s & bclk_d_q;

  sync2 #(.W(2)) u_link_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .async_in ({ac_sdata_in, ac_bit_clk}),
    .sync_out (link_s)
  );

  // transmit position
  logic [3:0]  slot_q;
  logic [4:0]  pos_q;
  logic [15:0] tag_q;
  logic [23:0] tx_cmd_q;
  logic [19:0] tx_gpio_q;
  ac_link_pkg::play_s tx_play_q;

  wire frame_start = rise & (slot_q == ac_link_pkg::SLOT_TAG) &
                     (pos_q == ac_link_pkg::TAG_LAST_POS);
  wire slot_end    = (pos_q == 5'h00);
  wire last_slot   = (slot_q == ac_link_pkg::SLOT_GPIO);

  // next tag from pending writes and playback enables
  logic [15:0] tag_d;
  always_comb begin
    tag_d = ac_link_pkg::RST_TAG;
    tag_d[ac_link_pkg::TAG_S1]  = cmd_pend;
    tag_d[ac_link_pkg::TAG_S2]  = cmd_pend;
    tag_d[ac_link_pkg::TAG_S3]  = play_en_q[ac_link_pkg::PLAY_LEFT_BIT];
    tag_d[ac_link_pkg::TAG_S4]  = play_en_q[ac_link_pkg::PLAY_RIGHT_BIT];
    tag_d[ac_link_pkg::TAG_S5]  = play_en_q[ac_link_pkg::PLAY_MODEM_BIT];
    tag_d[ac_link_pkg::TAG_S12] = gpio_pend;
    tag_d[ac_link_pkg::TAG_FRAME] = |{tag_d[14:10], tag_d[ac_link_pkg::TAG_S12]};
  end

  // outgoing slot word
  wire [19:0] w_tag   = frame_start ? {4'h0, tag_d} : {4'h0, tag_q};
  wire [19:0] w_cmd1  = {tx_cmd_q[ac_link_pkg::CMD_RW_BIT],
                         tx_cmd_q[22:16], 12'h000};
  wire [19:0] w_cmd2  = {tx_cmd_q[15:0], 4'h0};
  wire [19:0] w_left  = {tx_play_q.left, 4'h0};
  wire [19:0] w_right = {tx_play_q.right, 4'h0};
  wire [19:0] w_modem = {tx_play_q.modem, 4'h0};
  wire [19:0] tx_word = (slot_q == ac_link_pkg::SLOT_TAG)     ? w_tag :
                        (slot_q == ac_link_pkg::SLOT_CMD_IDX) ? w_cmd1 :
                        (slot_q == ac_link_pkg::SLOT_CMD_DAT) ? w_cmd2 :
                        (slot_q == ac_link_pkg::SLOT_LEFT)    ? w_left :
                        (slot_q == ac_link_pkg::SLOT_RIGHT)   ? w_right :
                        (slot_q == ac_link_pkg::SLOT_MODEM)   ? w_modem :
                        (slot_q == ac_link_pkg::SLOT_GPIO)    ? tx_gpio_q : 20'h0_0000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q       <= ac_link_pkg::SLOT_TAG;
      pos_q        <= ac_link_pkg::TAG_LAST_POS;
      ac_sync      <= 1'b0;
      ac_sdata_out <= 1'b0;
    end else if (rise) begin
      ac_sync      <= (slot_q == ac_link_pkg::SLOT_TAG);
      ac_sdata_out <= tx_word[pos_q];
      if (!slot_end) begin
        pos_q <= pos_q - 5'h01;
      end else if (last_slot) begin
        slot_q <= ac_link_pkg::SLOT_TAG;
        pos_q  <= ac_link_pkg::TAG_LAST_POS;
      end else begin
        slot_q <= slot_q + 4'h1;
        pos_q  <= ac_link_pkg::SLOT_LAST_POS;
      end
    end
  end

  // frame snapshot taken as the tag starts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tag_q     <= ac_link_pkg::RST_TAG;
      tx_cmd_q  <= 24'h00_0000;
      tx_gpio_q <= 20'h0_0000;
      tx_play_q <= '0;
      play_take <= 3'h0;
    end else begin
      play_take <= 3'h0;
      if (frame_start) begin
        tag_q     <= tag_d;
        tx_cmd_q  <= cmd_word_q[23:0];
        tx_gpio_q <= gpio_wr_q;
        tx_play_q <= play_sample;
        play_take <= play_en_q;
      end
    end
  end

  // receive: bit sampled on the falling edge of the bit clock
  logic [3:0]  rx_slot_q;
  logic [4:0]  rx_pos_q;
  logic [18:0] rx_sh_q;
  logic [15:0] in_tag_q;
  wire  [19:0] rx_word = {rx_sh_q, sdin_s};
  wire         rx_done = fall & (rx_pos_q == 5'h00);

  wire in_s1  = in_tag_q[ac_link_pkg::TAG_S1];
  wire in_s2  = in_tag_q[ac_link_pkg::TAG_S2];
  wire in_s3  = in_tag_q[ac_link_pkg::TAG_S3];
  wire in_s4  = in_tag_q[ac_link_pkg::TAG_S4];
  wire in_s5  = in_tag_q[ac_link_pkg::TAG_S5];
  wire in_s6  = in_tag_q[ac_link_pkg::TAG_S6];
  wire in_s12 = in_tag_q[ac_link_pkg::TAG_S12];

  wire got_tag  = rx_done & (rx_slot_q == ac_link_pkg::SLOT_TAG);
  wire got_idx  = rx_done & (rx_slot_q == ac_link_pkg::SLOT_CMD_IDX) & in_s1;
  wire got_dat  = rx_done & (rx_slot_q == ac_link_pkg::SLOT_CMD_DAT) & in_s2;
  wire got_left = rx_done & (((rx_slot_q == ac_link_pkg::SLOT_LEFT) & in_s3) |
                             ((rx_slot_q == ac_link_pkg::SLOT_MIC) & in_s6));
  wire got_rght = rx_done & (rx_slot_q == ac_link_pkg::SLOT_RIGHT) & in_s4;
  wire got_mdm  = rx_done & (rx_slot_q == ac_link_pkg::SLOT_MODEM) & in_s5;
  wire got_gpio = rx_done & (rx_slot_q == ac_link_pkg::SLOT_GPIO) & in_s12;

  assign flag_set = {got_gpio, got_dat, got_idx, wr_gpio, wr_cmd};
  assign flag_clr = {rd_gpio, rd_cmd, rd_cmd, frame_start & tag_d[ac_link_pkg::TAG_S12],
                     frame_start & tag_d[ac_link_pkg::TAG_S1]};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_slot_q <= ac_link_pkg::SLOT_TAG;
      rx_pos_q  <= ac_link_pkg::RX_IDLE_POS;
      rx_sh_q   <= 19'h0_0000;
      bclk_d_q  <= 1'b0;
    end else begin
      bclk_d_q <= bclk_s;
      if (rise) begin
        rx_slot_q <= slot_q;
        rx_pos_q  <= pos_q;
      end
      if (fall) begin
        rx_sh_q <= rx_word[18:0];
      end
    end
  end

  // captured fields
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_tag_q   <= ac_link_pkg::RST_TAG;
      ret_idx_q  <= 7'h00;
      ret_data_q <= 16'h0000;
      req_q      <= 10'h000;
      gpio_rd_q  <= 20'h0_0000;
    end else begin
      if (got_tag) begin
        in_tag_q <= rx_word[15:0];
      end
      if (got_idx) begin
        ret_idx_q <= rx_word[18:12];
        req_q     <= rx_word[11:2];
      end
      if (got_dat) begin
        ret_data_q <= rx_word[19:4];
      end
      if (got_gpio) begin
        gpio_rd_q <= rx_word;
      end
    end
  end

  // record hand-off and status events, one-cycle strobes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_out      <= '0;
      status_event <= '0;
    end else begin
      rec_out.left_valid  <= got_left;
      rec_out.right_valid <= got_rght;
      rec_out.modem_valid <= got_mdm;
      if (got_left) begin
        rec_out.left <= rx_word[19:4];
      end
      if (got_rght) begin
        rec_out.right <= rx_word[19:4];
      end
      if (got_mdm) begin
        rec_out.modem <= rx_word[19:4];
      end
      status_event.status_index <= got_idx;
      status_event.status_data  <= got_dat;
      status_event.gpio_status  <= got_gpio;
      status_event.gpio_int     <= got_gpio & rx_word[0];
    end
  end

endmodule

// ==== testbench/ac_link_slot_formatter_props.sv ====
// protocol checker for the ac-link slot formatter
`timescale 1ns/100ps
module ac_link_slot_formatter_props (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire logic [4:0]          avs_address,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest,
  input wire logic                ac_sync,
  input wire logic                ac_sdata_out,
  input wire logic [2:0]          play_take,
  input wire ac_link_pkg::rec_s   rec_out,
  input wire ac_link_pkg::event_s status_event
);
  logic [15:0] cnt_q, tag_q, cw_q;
  logic        sync_q;
  wire mid     = ac_sync && (cnt_q % 16'h0019 == 16'h000c) && (cnt_q < 16'h0190);
  wire tag_end = !ac_sync && sync_q;
  wire cmd_wr  = avs_write && !avs_waitrequest && avs_address == ac_link_pkg::OFS_CMD_WRITE;
  wire cmd_out = tag_end && tag_q[14] && tag_q[13];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {cnt_q, tag_q, cw_q, sync_q} <= '0;
    end else begin
      sync_q <= ac_sync;
      cnt_q  <= (ac_sync && !sync_q) ? 16'h0001 : cnt_q + 16'h0001;
      tag_q  <= mid ? {tag_q[14:0], ac_sdata_out} : tag_q;
      cw_q   <= cmd_wr ? 16'h0001 : cmd_out ? 16'h0000 : cw_q + {15'h0, |cw_q};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_tag_end;
    $fell(ac_sync);
  endsequence
  sequence s_start;
    ac_sync && cnt_q < 16'h0004;
  endsequence
  AST_SYNC_LEN: assert property (s_tag_end |-> cnt_q inside {[16'h018d:16'h0193]})
    else $error("tag phase length wrong");
  AST_FRAME_BIT: assert property (s_tag_end |-> tag_q[15] == |{tag_q[14:10], tag_q[3]})
    else $error("frame valid bit wrong");
  AST_TAG_ZERO: assert property (s_tag_end |-> tag_q[9:4] == 6'h00 && tag_q[2:0] == 3'h0)
    else $error("fixed tag bits not zero");
  AST_CMD_TAG: assert property (cw_q < 16'h1b58)
    else $error("command slots not sent");
  AST_TAKE_START: assert property (|play_take |-> ##[0:3] s_start)
    else $error("playback take away from frame start");
  AST_GPIO_INT: assert property (status_event.gpio_int |-> status_event.gpio_status)
    else $error("gpio event without slot capture");
  AST_EVT_PULSE: assert property (status_event.status_index |=> !status_event.status_index [*8])
    else $error("status event repeated");
  AST_REC_HOLD: assert property ($changed(rec_out.left) |-> rec_out.left_valid)
    else $error("record data changed without valid");
endmodule
bind ac_link_slot_formatter ac_link_slot_formatter_props u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .ac_sync(ac_sync), .ac_sdata_out(ac_sdata_out),
  .play_take(play_take), .rec_out(rec_out), .status_event(status_event));

// ==== testbench/ac_codec_model.sv ====
// behavioural codec on the far side of the ac-link
`timescale 1ns/100ps
module ac_codec_model (
  output logic              ac_bit_clk,
  output logic              ac_sdata_in,
  input  wire logic         ac_sync,
  input  wire logic         ac_sdata_out,
  input  wire logic [255:0] in_frame,
  output logic      [255:0] out_frame,
  output logic      [15:0]  fcnt
);
  logic [255:0] sh, tx;
  logic [7:0]   idx;
  logic         sp, lk;
  initial begin
    {ac_bit_clk, ac_sdata_in, sp, lk, sh, tx, out_frame, idx, fcnt} = '0;
  end
  always #62.5 ac_bit_clk = ~ac_bit_clk;
  always @(negedge ac_bit_clk) begin
    idx = (ac_sync && !sp) ? 8'h00 : idx + 8'h01; // frames follow sync
    lk  = lk | (ac_sync && !sp);
    sp  = ac_sync;
    sh  = {sh[254:0], ac_sdata_out}; // msb first
    if (lk && idx == 8'hff) begin
      out_frame = sh;
      fcnt = fcnt + 16'h0001;
    end
  end
  always @(posedge ac_bit_clk) begin
    if (lk && idx == 8'hff) begin
      tx = in_frame;
      tx[255] = |{tx[254:250], tx[243]};
    end
    ac_sdata_in <= lk ? tx[8'hff - (idx + 8'h01)] : ~ac_sdata_in;
  end
endmodule

// ==== testbench/ac_link_slot_formatter_test.sv ====
// self-checking bench for the ac-link slot formatter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module ac_link_slot_formatter_test;
  logic                rst_n = 1'b0, ref_clk = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0]          avs_address = '0;
  logic [31:0]         avs_writedata = '0, avs_readdata, seed = 32'h0000000b;
  logic                avs_waitrequest, ac_bit_clk, ac_sdata_in, ac_sync, ac_sdata_out;
  ac_link_pkg::play_s  play_sample = '0;
  logic [2:0]          play_take;
  ac_link_pkg::rec_s   rec_out;
  ac_link_pkg::event_s status_event;
  logic [255:0]        in_frame = '0, out_frame, fr;
  logic [15:0]         fcnt;
  logic [35:0]         q[$];
  int                  n_fail = 0, total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  ac_link_slot_formatter DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ac_bit_clk(ac_bit_clk), .ac_sdata_in(ac_sdata_in), .ac_sync(ac_sync),
    .ac_sdata_out(ac_sdata_out), .play_sample(play_sample), .play_take(play_take),
    .rec_out(rec_out), .status_event(status_event));
  ac_codec_model codec (.ac_bit_clk(ac_bit_clk), .ac_sdata_in(ac_sdata_in), .ac_sync(ac_sync),
    .ac_sdata_out(ac_sdata_out), .in_frame(in_frame), .out_frame(out_frame), .fcnt(fcnt));
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic pop(input string nm, input logic [35:0] got);
    logic [35:0] e;
    e = (q.size() > 0) ? q.pop_front() : '1;
    `CHK(nm, e, got)
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    i = 0;
    do begin @(posedge ref_clk); i++; end while (avs_waitrequest !== 1'b0 && i < 50);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin n_fail++; wrap_up(); end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    q.push_back({4'h0, e});
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic wait_frame();
    logic [15:0] f;
    int i;
    f = fcnt;
    for (i = 0; i < 20000 && fcnt == f; i++) @(posedge ref_clk);
    if (i == 20000) begin n_fail++; wrap_up(); end
  endtask
  always @(negedge ref_clk) begin
    if (rst_n && avs_read && !avs_waitrequest && q.size() > 0 && q[0][35:32] == 4'h0)
      pop("readdata", {4'h0, avs_readdata});
    if (rec_out.left_valid) pop("left", {20'h10000, rec_out.left});
    if (rec_out.right_valid) pop("right", {20'h20000, rec_out.right});
    if (rec_out.modem_valid) pop("modem", {20'h30000, rec_out.modem});
    if (status_event.status_index) pop("st_index", 36'h400000000);
    if (status_event.status_data) pop("st_data", 36'h500000000);
    if (status_event.gpio_status) pop("gpio", 36'h600000000);
    if (status_event.gpio_int) pop("gpio_int", 36'h700000000);
  end
  initial begin
    logic [31:0] r, g, cmd, gp;
    logic [15:0] t;
    logic [2:0]  en;
    logic [6:0]  vs, xi;
    logic        cw, gw, iv, dv, gv;
    logic [15:0] xd;
    logic [9:0]  xr;
    logic [19:0] xg;
    {iv, dv, gv, xi, xd, xr, xg} = '0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 7; a++) rdc(5'(a * 4), ac_link_pkg::RST_WORD);
    for (int it = 0; it < 4; it++) begin
      r = rnd();
      cw = (it == 0) | (it > 1 & r[0]);
      gw = (it == 0) | (it > 1 & r[1]);
      en = (it == 0) ? 3'h7 : (it == 1) ? 3'h0 : r[4:2];
      vs = (it == 0) ? 7'h5f : (it == 1) ? 7'h00 : (it == 2) ? 7'h63 : r[11:5];
      vs[5] = vs[5] & ~vs[2]; // slots 3 and 6 never together
      cmd = rnd();
      gp = rnd();
      for (int k = 0; k < 8; k++) fr[k*32 +: 32] = rnd();
      fr[255:240] = {1'b0, vs[0], vs[1], vs[2], vs[3], vs[4], vs[5], 5'h00, vs[6], 3'h0};
      fr[0] = fr[0] | (it == 0);
      if (vs[0]) begin q.push_back(36'h400000000); {iv, xi, xr} = {1'b1, fr[238:222]}; end
      if (vs[1]) begin q.push_back(36'h500000000); {dv, xd} = {1'b1, fr[219:204]}; end
      if (vs[2]) q.push_back({20'h10000, fr[199:184]});
      if (vs[3]) q.push_back({20'h20000, fr[179:164]});
      if (vs[4]) q.push_back({20'h30000, fr[159:144]});
      if (vs[5]) q.push_back({20'h10000, fr[139:124]});
      if (vs[6]) begin q.push_back(36'h600000000); {gv, xg} = {1'b1, fr[19:0]}; end
      if (vs[6] && fr[0]) q.push_back(36'h700000000);
      play_sample <= fr[95:48];
      in_frame <= fr;
      bus(1'b1, ac_link_pkg::OFS_PLAY_CTRL, {29'h0, en}, r);
      if (cw) bus(1'b1, ac_link_pkg::OFS_CMD_WRITE, cmd, r);
      if (gw) bus(1'b1, ac_link_pkg::OFS_GPIO_WRITE, gp, r);
      if (!cw && !gw) wait_frame();
      r = 32'h80000000;
      for (int i = 0; i < 3000 && (r[31] || g[31]); i++) begin
        bus(1'b0, ac_link_pkg::OFS_CMD_WRITE, 32'h0, r);
        bus(1'b0, ac_link_pkg::OFS_GPIO_WRITE, 32'h0, g);
      end
      `CHK("busy", 1'b0, r[31] | g[31])
      wait_frame();
      in_frame <= '0;
      t = {cw | gw | (|en), cw, cw, en[0], en[1], en[2], 6'h00, gw, 3'h0};
      `CHK("tag", t, out_frame[255:240])
      if (cw) `CHK("slot1", {cmd[23:16], 12'h000}, out_frame[239:220])
      if (cw) `CHK("slot2", {cmd[15:0], 4'h0}, out_frame[219:200])
      if (en[0]) `CHK("slot3", {play_sample.left, 4'h0}, out_frame[199:180])
      if (en[1]) `CHK("slot4", {play_sample.right, 4'h0}, out_frame[179:160])
      if (en[2]) `CHK("slot5", {play_sample.modem, 4'h0}, out_frame[159:140])
      if (gw) `CHK("slot12", gp[19:0], out_frame[19:0])
      `CHK("unused", 120'h0, out_frame[139:20])
      repeat (30) @(posedge ref_clk);
      rdc(ac_link_pkg::OFS_CMD_READ, {6'h00, dv, iv, 1'b0, xi, xd});
      rdc(ac_link_pkg::OFS_CODEC_REQ, {22'h0, xr});
      rdc(ac_link_pkg::OFS_GPIO_READ, {gv, 11'h0, xg});
      {iv, dv, gv} = '0;
    end
    repeat (10) @(posedge ref_clk);
    `CHK("pending", 32'h0, 32'(q.size()))
    wrap_up();
  end
endmodule
